// ==== rtl/ppo_pkg.sv ====
// Constants for the port power / overcurrent control block.
// Assumes a single 200 MHz core clock and an AHB-Lite register bus.
package ppo_pkg;
    localparam int unsigned PPO_NUM_PORTS = 2;
    localparam int unsigned PPO_NUM_SPLIT = 3;
    localparam int unsigned PPO_NUM_GPIO = 4;
    localparam int unsigned PPO_GPIO_BASE = 70;
    // Cycles a freshly enabled port ignores its sense pin
    localparam int unsigned PPO_SENSE_BLANK_CYCLES = 4;
    // Register byte offsets
    localparam logic [7:0] PPO_CTRL_OFS = 8'h00;
    localparam logic [7:0] PPO_STAT_OFS = 8'h04;
    localparam logic [7:0] PPO_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] PPO_IRQ_MASK_OFS = 8'h0C;
    localparam logic [7:0] PPO_GPIO_OUT_OFS = 8'h10;
    localparam logic [7:0] PPO_GPIO_OE_OFS = 8'h14;
    localparam logic [7:0] PPO_GPIO_IN_OFS = 8'h18;
    // Control register fields
    localparam int unsigned PPO_CTRL_EN_POS = 0;
    localparam int unsigned PPO_CTRL_SPLIT_POS = 2;
    localparam int unsigned PPO_CTRL_SS_POS = 4;
    // Status register fields
    localparam int unsigned PPO_STAT_OC_POS = 0;
    localparam int unsigned PPO_STAT_SS_POS = 4;
    // Interrupt event bits: overcurrent per port
    localparam int unsigned PPO_IRQ_OC_POS = 0;
    localparam logic [31:0] PPO_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PPO_MASK_RST = 32'h0000_0000;
    localparam logic [1:0] PPO_HTRANS_NONSEQ = 2'b10;
endpackage

// ==== rtl/ppo_port_ctl.sv ====
// Port power pins, split-port enables and general I/O behind AHB-Lite.
// Assumes the pad adds the pull-up when pull_up_enable is high.
// A newly enabled port ignores its sense pin for a short settle window.
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
module ppo_port_ctl #(
    parameter int unsigned NUM_GPIO = ppo_pkg::PPO_NUM_GPIO
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic port1_power_sense_in,
    output logic port1_power_sense_out,
    output logic port1_power_sense_oe,
    output logic port1_pull_up_enable,
    input wire logic port2_power_sense_in,
    output logic port2_power_sense_out,
    output logic port2_power_sense_oe,
    output logic port2_pull_up_enable,
    output logic port4_superspeed_enable,
    output logic port3_superspeed_enable,
    output logic port2_superspeed_enable,
    input wire logic [NUM_GPIO-1:0] general_io_group_in,
    output logic [NUM_GPIO-1:0] general_io_group_out,
    output logic [NUM_GPIO-1:0] general_io_group_oe,
    output logic irq
);
    // Control fields
    logic [1:0] port_enable;
    logic split_port_mode;
    logic [2:0] ss_request;
    logic [31:0] irq_stat;
    logic [31:0] irq_mask;
    logic [NUM_GPIO-1:0] gpio_out;
    logic [NUM_GPIO-1:0] gpio_oe;
    // Pin synchronisers
    logic [1:0] sense_meta;
    logic [1:0] sense_sync;
    logic [1:0] oc_prev;
    logic [NUM_GPIO-1:0] gpio_meta;
    logic [NUM_GPIO-1:0] gpio_sync;
    logic [1:0] overcurrent;
    logic [1:0] oc_rise;
    logic [2:0] ss_active;
    // Pull-up settle window after a port is enabled
    localparam int unsigned BLANK_W = $clog2(ppo_pkg::PPO_SENSE_BLANK_CYCLES + 1);
    logic [BLANK_W-1:0] blank_count [2];
    logic [1:0] sense_armed;
    // Bus address phase capture
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr_q;
    logic addr_valid;

    // One decode for every register write strobe
    function automatic logic write_hit(input logic pend, input logic [7:0] addr,
            input logic [7:0] ofs);
        return pend && addr == ofs;
    endfunction

    assign addr_valid = hsel && hready && htrans == ppo_pkg::PPO_HTRANS_NONSEQ;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend <= addr_valid && hwrite;
            rd_pend <= addr_valid && !hwrite;
            addr_q <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Two-stage sync; only the second stage feeds logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sense_meta <= 2'b11;
            sense_sync <= 2'b11;
            gpio_meta <= '0;
            gpio_sync <= '0;
        end else begin
            sense_meta <= {port2_power_sense_in, port1_power_sense_in};
            sense_sync <= sense_meta;
            gpio_meta <= general_io_group_in;
            gpio_sync <= gpio_meta;
        end
    end

    // blank the sense for PPO_SENSE_BLANK_CYCLES cycles after enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < 2; p++) begin
                blank_count[p] <= '0;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (!port_enable[p]) begin
                    blank_count[p] <= '0;
                end else if (!sense_armed[p]) begin
                    blank_count[p] <= BLANK_W'(blank_count[p] + 1'b1);
                end
            end
        end
    end

    // Driven-low pin plus sync delay would otherwise read as a false event on enable
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            sense_armed[p] = blank_count[p] == BLANK_W'(ppo_pkg::PPO_SENSE_BLANK_CYCLES);
        end
    end

    // disabled port ignores its driven-low pin
    assign overcurrent = ~sense_sync & port_enable & sense_armed;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oc_prev <= 2'b00;
        end else begin
            oc_prev <= overcurrent;
        end
    end

    assign oc_rise = overcurrent & ~oc_prev;

    // Control register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_enable <= ppo_pkg::PPO_CTRL_RST[ppo_pkg::PPO_CTRL_EN_POS +: 2];
            split_port_mode <= ppo_pkg::PPO_CTRL_RST[ppo_pkg::PPO_CTRL_SPLIT_POS];
            ss_request <= ppo_pkg::PPO_CTRL_RST[ppo_pkg::PPO_CTRL_SS_POS +: 3];
        end else if (write_hit(wr_pend, addr_q, ppo_pkg::PPO_CTRL_OFS)) begin
            port_enable <= hwdata[ppo_pkg::PPO_CTRL_EN_POS +: 2];
            split_port_mode <= hwdata[ppo_pkg::PPO_CTRL_SPLIT_POS];
            ss_request <= hwdata[ppo_pkg::PPO_CTRL_SS_POS +: 3];
        end
    end

    // Sticky events: set wins over write-one-to-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= 32'h0000_0000;
        end else begin
            logic [31:0] clr;
            logic [31:0] set;
            clr = write_hit(wr_pend, addr_q, ppo_pkg::PPO_IRQ_STAT_OFS) ? hwdata : 32'h0000_0000;
            set = 32'h0000_0000;
            set[ppo_pkg::PPO_IRQ_OC_POS +: 2] = oc_rise;
            irq_stat <= (irq_stat & ~clr) | set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= ppo_pkg::PPO_MASK_RST;
        end else if (write_hit(wr_pend, addr_q, ppo_pkg::PPO_IRQ_MASK_OFS)) begin
            irq_mask <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gpio_out <= '0;
            gpio_oe <= '0;
        end else if (write_hit(wr_pend, addr_q, ppo_pkg::PPO_GPIO_OUT_OFS)) begin
            gpio_out <= hwdata[NUM_GPIO-1:0];
        end else if (write_hit(wr_pend, addr_q, ppo_pkg::PPO_GPIO_OE_OFS)) begin
            gpio_oe <= hwdata[NUM_GPIO-1:0];
        end
    end

    assign general_io_group_out = gpio_out;
    assign general_io_group_oe = gpio_oe;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // enabled pin is input with pull-up
    // port 1 pin always covers both halves
    // split off leaves the pin over both halves
    // split on narrows pin to the USB2 half
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port1_power_sense_out <= 1'b0;
            port1_power_sense_oe <= 1'b1;
            port1_pull_up_enable <= 1'b0;
            port2_power_sense_out <= 1'b0;
            port2_power_sense_oe <= 1'b1;
            port2_pull_up_enable <= 1'b0;
        end else begin
            port1_power_sense_out <= 1'b0;
            port1_power_sense_oe <= !port_enable[0];
            port1_pull_up_enable <= port_enable[0];
            port2_power_sense_out <= 1'b0;
            port2_power_sense_oe <= !port_enable[1];
            port2_pull_up_enable <= port_enable[1];
        end
    end

    // low unless split on and requested
    always_comb begin
        ss_active = 3'b000;
        if (split_port_mode) begin
            ss_active = ss_request;
            // Ports 3 and 4 are gated by their own enables outside this block
            ss_active[0] = ss_request[0] && port_enable[1];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port2_superspeed_enable <= 1'b0;
            port3_superspeed_enable <= 1'b0;
            port4_superspeed_enable <= 1'b0;
        end else begin
            port2_superspeed_enable <= ss_active[0];
            port3_superspeed_enable <= ss_active[1];
            port4_superspeed_enable <= ss_active[2];
        end
    end

    // Read data decoded combinationally in the data phase from the registered address
    always_comb begin
        hrdata = 32'h0000_0000;
        if (rd_pend) begin
            case (addr_q)
                ppo_pkg::PPO_CTRL_OFS: begin
                    hrdata[ppo_pkg::PPO_CTRL_EN_POS +: 2] = port_enable;
                    hrdata[ppo_pkg::PPO_CTRL_SPLIT_POS] = split_port_mode;
                    hrdata[ppo_pkg::PPO_CTRL_SS_POS +: 3] = ss_request;
                end
                ppo_pkg::PPO_STAT_OFS: begin
                    hrdata[ppo_pkg::PPO_STAT_OC_POS +: 2] = overcurrent;
                    hrdata[ppo_pkg::PPO_STAT_SS_POS +: 3] = ss_active;
                end
                ppo_pkg::PPO_IRQ_STAT_OFS: hrdata = irq_stat;
                ppo_pkg::PPO_IRQ_MASK_OFS: hrdata = irq_mask;
                ppo_pkg::PPO_GPIO_OUT_OFS: hrdata[NUM_GPIO-1:0] = gpio_out;
                ppo_pkg::PPO_GPIO_OE_OFS: hrdata[NUM_GPIO-1:0] = gpio_oe;
                ppo_pkg::PPO_GPIO_IN_OFS: hrdata[NUM_GPIO-1:0] = gpio_sync;
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Assertions
    drive_low_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !port_enable[0] |=> port1_power_sense_oe && !port1_power_sense_out)
        else $error("Disabled port 1 pin not driven low");
    pullup_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
        port_enable[1] |=> port2_pull_up_enable && !port2_power_sense_oe)
        else $error("Enabled port 2 pin not a pulled-up input");
    oc_detect_a: assert property (@(posedge hclk) disable iff (!hresetn)
        overcurrent[0] && !oc_prev[0] |=> irq_stat[ppo_pkg::PPO_IRQ_OC_POS])
        else $error("Overcurrent event not latched");
    float_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !port_enable[1] && !irq_stat[ppo_pkg::PPO_IRQ_OC_POS + 1]
            |=> !irq_stat[ppo_pkg::PPO_IRQ_OC_POS + 1])
        else $error("Disabled port reported overcurrent");
    ss_split_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !split_port_mode ##1 !split_port_mode |-> !port4_superspeed_enable)
        else $error("Superspeed enable high with split off");
    ss_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        split_port_mode && ss_request[1] |=> port3_superspeed_enable)
        else $error("Port 3 superspeed enable not driven");
    ss_idle_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(split_port_mode) |-> !port2_superspeed_enable)
        else $error("Port 2 superspeed enable not held low");
    port1_both_a: assert property (@(posedge hclk) disable iff (!hresetn)
        split_port_mode && port_enable[0] |=> port1_pull_up_enable)
        else $error("Port 1 pin follows split mode");
    irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        |(irq_stat & irq_mask) |=> irq)
        else $error("Interrupt not raised");
    drive_low_p2_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !port_enable[1] |=> port2_power_sense_oe && !port2_power_sense_out)
        else $error("Disabled port 2 pin not driven low");
    pullup_p1_a: assert property (@(posedge hclk) disable iff (!hresetn)
        port_enable[0] |=> port1_pull_up_enable && !port1_power_sense_oe)
        else $error("Enabled port 1 pin not a pulled-up input");
    oc_detect_p2_a: assert property (@(posedge hclk) disable iff (!hresetn)
        overcurrent[1] && !oc_prev[1] |=> irq_stat[ppo_pkg::PPO_IRQ_OC_POS + 1])
        else $error("Port 2 overcurrent event not latched");
    oc_blank_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(port_enable[0]) |-> (!overcurrent[0]) [*3])
        else $error("Overcurrent flagged before the pin settled");
    port1_split_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !split_port_mode && port_enable[0] |=> port1_pull_up_enable)
        else $error("Port 1 pin dropped with split off");
    split_off_p2_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !split_port_mode && port_enable[1] |=> port2_pull_up_enable)
        else $error("Port 2 pin dropped with split off");
    split_on_p2_a: assert property (@(posedge hclk) disable iff (!hresetn)
        split_port_mode && port_enable[1] |=> port2_pull_up_enable && !port2_power_sense_oe)
        else $error("Port 2 pin not kept for the USB2 half");
    ss3_split_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !split_port_mode |=> !port3_superspeed_enable)
        else $error("Port 3 superspeed enable high with split off");
    ss_port_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !port_enable[1] |=> !port2_superspeed_enable)
        else $error("Port 2 superspeed enable high while port off");
    irq_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|(irq_stat & irq_mask)) |=> !irq)
        else $error("Interrupt held without a pending event");
    cov_oc: cover property (@(posedge hclk) disable iff (!hresetn) oc_rise[1]);
    cov_split: cover property (@(posedge hclk) disable iff (!hresetn)
        split_port_mode && port4_superspeed_enable);
    cov_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq);
    cov_ss_gated: cover property (@(posedge hclk) disable iff (!hresetn)
        split_port_mode && ss_request[0] && !port_enable[1]);
    cov_w1c: cover property (@(posedge hclk) disable iff (!hresetn)
        write_hit(wr_pend, addr_q, ppo_pkg::PPO_IRQ_STAT_OFS) && |irq_stat);
endmodule

// ==== tb/ppo_port_ctl_tb.sv ====
// Self-checking bench for the port power block.
// Assumes a zero-wait AHB-Lite slave and two switch models on the pins.
`timescale 1ns/100ps
module ppo_port_ctl_tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, oc1 = 0, oc2 = 0;
    logic [31:0] haddr = '0, hwdata = '0, rd;
    logic [1:0] htrans = '0;
    logic [3:0] gin = '0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, pin1, pin2, so1, oe1, pu1, so2, oe2, pu2, ss4, ss3, ss2, irq;
    logic [3:0] gout, goe;
    int seed = 87643, fail_count = 0, check_count = 0, req, exp, i;
    always #2.5 hclk = ~hclk;
    ppo_port_ctl ppo_port_ctl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .port1_power_sense_in(pin1), .port1_power_sense_out(so1),
        .port1_power_sense_oe(oe1), .port1_pull_up_enable(pu1),
        .port2_power_sense_in(pin2), .port2_power_sense_out(so2),
        .port2_power_sense_oe(oe2), .port2_pull_up_enable(pu2),
        .port4_superspeed_enable(ss4), .port3_superspeed_enable(ss3),
        .port2_superspeed_enable(ss2), .general_io_group_in(gin),
        .general_io_group_out(gout), .general_io_group_oe(goe), .irq(irq));
    ppo_switch_model sw1_inst (.sense_out(so1), .sense_oe(oe1), .pull_up(pu1),
        .overcurrent(oc1), .pin(pin1), .power_on());
    ppo_switch_model sw2_inst (.sense_out(so2), .sense_oe(oe2), .pull_up(pu2),
        .overcurrent(oc2), .pin(pin2), .power_on());
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
        check_count++;
        if (seen !== expv) begin
            $display("CHECK FAILED %s expected %h seen %h", name, expv, seen);
            fail_count++;
        end
    endtask
    // Bounded wait for hready at a rising edge
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            tally_and_finish;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= ppo_pkg::PPO_HTRANS_NONSEQ;
        wait_ready();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        check("hresp", hresp, 0);
    endtask
    task automatic settle;
        repeat (6) @(posedge hclk);
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("port1 off", {oe1, so1, pin1}, 3'b100);
        check("pin2", pin2, 0);
        check("ss", {ss4, ss3, ss2}, 0);
        for (i = 0; i < 16; i += 4) begin
            bus(0, 8'(i), 0);
            check("reset reg", rd, 0);
        end
        $display("reset test done");
        bus(1, ppo_pkg::PPO_CTRL_OFS, 3);
        settle();
        check("pu1", {pu1, pu2, oe1, oe2, pin1}, 5'b11001);
        bus(0, ppo_pkg::PPO_IRQ_STAT_OFS, 0);
        check("no false oc", rd, 0);
        bus(0, 8'h1C, 0);
        check("unmapped", rd, 0);
        for (i = 0; i < 6; i++) begin
            req = $random(seed) & 7;
            bus(1, ppo_pkg::PPO_CTRL_OFS, 3 | ((i & 1) << 2) | (req << 4));
            settle();
            exp = (i & 1) ? req : 0;
            check("ss", {ss4, ss3, ss2}, exp);
            check("pins", {pu1, pu2, oe1, oe2}, 4'b1100);
            bus(0, ppo_pkg::PPO_STAT_OFS, 0);
            check("stat ss", rd, exp << 4);
        end
        $display("split test done");
        bus(1, ppo_pkg::PPO_IRQ_MASK_OFS, 1);
        oc1 <= 1'b1;
        settle();
        check("irq", irq, 1);
        bus(0, ppo_pkg::PPO_STAT_OFS, 0);
        check("oc live", rd[1:0], 2'b01);
        oc1 <= 1'b0;
        oc2 <= 1'b1;
        bus(1, ppo_pkg::PPO_IRQ_STAT_OFS, 1);
        settle();
        check("irq masked", irq, 0);
        bus(0, ppo_pkg::PPO_IRQ_STAT_OFS, 0);
        check("irq stat", rd, 2);
        oc2 <= 1'b0;
        bus(1, ppo_pkg::PPO_CTRL_OFS, 1);
        bus(1, ppo_pkg::PPO_IRQ_STAT_OFS, 2);
        settle();
        check("off pin", {oe2, so2, pu2, pin2}, 4'b1000);
        bus(1, ppo_pkg::PPO_CTRL_OFS, 1 | 4 | (7 << 4));
        settle();
        check("ss gated", {ss4, ss3, ss2}, 3'b110);
        bus(0, ppo_pkg::PPO_STAT_OFS, 0);
        check("stat gated", rd, 32'h0000_0060);
        oc2 <= 1'b1;
        settle();
        bus(0, ppo_pkg::PPO_STAT_OFS, 0);
        check("off oc", rd[1], 0);
        oc2 <= 1'b0;
        $display("overcurrent test done");
        req = $random(seed);
        bus(1, ppo_pkg::PPO_GPIO_OUT_OFS, req & 15);
        bus(1, ppo_pkg::PPO_GPIO_OE_OFS, (req >> 4) & 15);
        gin <= req[11:8];
        settle();
        check("gpio out", {goe, gout}, req & 8'hFF);
        bus(0, ppo_pkg::PPO_GPIO_IN_OFS, 0);
        check("gpio in", rd, (req >> 8) & 15);
        bus(0, ppo_pkg::PPO_GPIO_OE_OFS, 0);
        check("gpio oe rb", rd, (req >> 4) & 15);
        $display("gpio test done");
        tally_and_finish;
    end
endmodule

// ==== tb/ppo_switch_model.sv ====
// External power switch and current monitor on one shared power pin.
// Assumes the device pad pulls up when pull_up is high and nothing drives.
`timescale 1ns/100ps
module ppo_switch_model (
    input wire logic sense_out,
    input wire logic sense_oe,
    input wire logic pull_up,
    input wire logic overcurrent,
    output logic pin,
    output logic power_on
);
    always_comb begin
        if (sense_oe) begin
            pin = sense_out;
        end else if (overcurrent) begin
            pin = 1'b0;
        end else begin
            pin = pull_up;
        end
        // Switch follows the pin level
        power_on = pin;
    end
endmodule
